// File: core/agd_pkg.sv
// Operation
// - adaptive gate control runs only when the selector holds binary 10 or 11.
// - pre-charge current tunes turn-on delay, pre-discharge current tunes turn-off delay.
// - each of three channels has its own software target on and off delays.
// - measured on and off delays of each channel are readable status registers.
// - adapted pre-charge and pre-discharge currents never exceed the channel maximum.
// - post-charge phase drives the gate with the channel maximum current.
// - each half-bridge has separate active and freewheel cross-current protection times.
// - each half-bridge has active and freewheel blank times masking overvoltage detection.
// - enabled channel selects half-bridge 000..111; its mode picks low or high side.
// - the freewheel transistor is on only in the idle phase, and stays off during protection times and pre-discharge.
// - pre-charge duration is chosen by a two-bit per-channel field.
package agd_pkg;

  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned NUM_CH        = 3;
  localparam int unsigned NUM_HB        = 8;

  // register byte offsets
  localparam logic [7:0] OFF_GEN    = 8'h00;
  localparam logic [7:0] OFF_HALFBRIDGE_MODE = 8'h04;
  localparam logic [7:0] OFF_PWMCFG = 8'h08; // three words
  localparam logic [7:0] OFF_TARGET = 8'h14; // three words
  localparam logic [7:0] OFF_IMAX   = 8'h20; // three words
  localparam logic [7:0] OFF_HBTIME = 8'h30; // eight words
  localparam logic [7:0] OFF_MEAS   = 8'h50; // three words, read only
  localparam logic [7:0] OFF_CURR   = 8'h60; // three words, read only
  localparam logic [7:0] OFF_STATUS = 8'h70; // read only

  // field positions
  localparam int unsigned GEN_AGS_LSB  = 0;
  localparam int unsigned PWM_EN_BIT   = 0;
  localparam int unsigned PWM_HB_LSB   = 1;
  localparam int unsigned PWM_TP_LSB   = 4;
  localparam int unsigned TGT_ON_LSB   = 0;
  localparam int unsigned TGT_OFF_LSB  = 8;
  localparam int unsigned HT_CCPA_LSB  = 0;
  localparam int unsigned HT_CCPF_LSB  = 8;
  localparam int unsigned HT_BLKA_LSB  = 16;
  localparam int unsigned HT_BLKF_LSB  = 24;
  localparam int unsigned CUR_PRE_LSB  = 0;
  localparam int unsigned CUR_PDC_LSB  = 8;
  localparam int unsigned ST_FLT_LSB   = 0;
  localparam int unsigned ST_CNF_LSB   = 8;

  // reset values
  localparam logic [1:0]  GEN_RST    = 2'h0;
  localparam logic [15:0] HALFBRIDGE_MODE_RST = 16'h0000;
  localparam logic [5:0]  PWMCFG_RST = 6'h00;
  localparam logic [15:0] TARGET_RST = 16'h1010;
  localparam logic [4:0]  IMAX_RST   = 5'h10;
  localparam logic [31:0] HBTIME_RST = 32'h10101010;
  localparam logic [4:0]  CUR_INIT   = 5'h04;

  // selector values 10 and 11 both have the upper bit set
  localparam int unsigned AGS_ADAPT_BIT = 1;
  localparam logic [1:0]  HB_MODE_LS    = 2'h1;
  localparam logic [1:0]  HB_MODE_HS    = 2'h2;

  // pre-charge durations, rounded up to whole cycles
  localparam int unsigned TPCHG0_NS = 100;
  localparam int unsigned TPCHG1_NS = 200;
  localparam int unsigned TPCHG2_NS = 400;
  localparam int unsigned TPCHG3_NS = 800;
  localparam logic [7:0] TPCHG0_CYC = 8'((TPCHG0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] TPCHG1_CYC = 8'((TPCHG1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] TPCHG2_CYC = 8'((TPCHG2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] TPCHG3_CYC = 8'((TPCHG3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam logic [7:0] MEAS_MAX = 8'hFF;

  typedef enum logic [2:0] {
    PH_OFF, PH_CCP_ON, PH_PRE, PH_POST, PH_CCP_OFF, PH_PREDIS
  } agd_phase_e;

endpackage

// File: core/agd_chan.sv
`timescale 1ns/1ps
module agd_chan
  import agd_pkg::*;
(
  input  wire logic       clk,       // core clock
  input  wire logic       rstn,      // async reset, active low
  input  wire logic       ce,        // clock enable
  input  wire logic       mapped,    // channel drives a half-bridge
  input  wire logic       adapt,     // adaptive control selected
  input  wire logic       pwm,       // waveform from the pin
  input  wire logic       fb_on,     // switch node reached turn-on level
  input  wire logic       fb_off,    // switch node reached turn-off level
  input  wire logic [7:0] ccp_act,   // active protection cycles
  input  wire logic [7:0] ccp_fw,    // freewheel protection cycles
  input  wire logic [7:0] blk_act,   // active blank cycles
  input  wire logic [7:0] blk_fw,    // freewheel blank cycles
  input  wire logic [7:0] tpchg,     // pre-charge cycles
  input  wire logic [7:0] tgt_on,    // target turn-on delay
  input  wire logic [7:0] tgt_off,   // target turn-off delay
  input  wire logic [4:0] imax,      // channel maximum current
  output logic            act_on,    // active transistor on
  output logic            fw_on,     // freewheel transistor on
  output logic            blanking,  // overvoltage detection masked
  output logic [4:0]      cur,       // gate current code now applied
  output logic [7:0]      meas_on,   // last turn-on delay
  output logic [7:0]      meas_off,  // last turn-off delay
  output logic [4:0]      ipre,      // adapted pre-charge current
  output logic [4:0]      ipdc       // adapted pre-discharge current
);

  agd_phase_e ph_reg, ph_next;
  logic [7:0] tmr_reg, tmr_next;
  logic [7:0] dly_reg;
  logic [7:0] blk_reg;
  logic       seen_reg;
  logic       pwm_reg;

  wire rise     = pwm & ~pwm_reg;
  wire tmr_done = (tmr_reg == 8'h00);
  wire dly_sat  = (dly_reg == MEAS_MAX);
  wire meas_ph  = (ph_reg == PH_PRE) || (ph_reg == PH_POST);
  wire on_hit   = meas_ph && !seen_reg && (fb_on || dly_sat);
  wire off_hit  = (ph_reg == PH_PREDIS) && (fb_off || dly_sat);
  wire [4:0] ipre_cl = (ipre > imax) ? imax : ipre;
  wire [4:0] ipdc_cl = (ipdc > imax) ? imax : ipdc;

  // phase sequence driven by the pin waveform, the phase timer and the turn-off feedback
  always_comb begin
    ph_next  = ph_reg;
    tmr_next = tmr_done ? 8'h00 : tmr_reg - 8'h01;
    unique case (ph_reg)
      PH_OFF: if (mapped && rise) begin
        ph_next  = PH_CCP_ON;
        tmr_next = ccp_fw;
      end
      PH_CCP_ON: if (!pwm) begin
        ph_next = PH_OFF;
      end else if (tmr_done) begin
        ph_next  = adapt ? PH_PRE : PH_POST;
        tmr_next = tpchg;
      end
      PH_PRE: if (!pwm) begin
        ph_next  = PH_CCP_OFF;
        tmr_next = ccp_act;
      end else if (tmr_done) begin
        ph_next = PH_POST;
      end
      PH_POST: if (!pwm) begin
        ph_next  = PH_CCP_OFF;
        tmr_next = ccp_act;
      end
      PH_CCP_OFF: if (tmr_done) begin
        ph_next = PH_PREDIS;
      end
      PH_PREDIS: if (off_hit) begin
        ph_next = PH_OFF;
      end
    endcase
    if (!mapped) begin
      ph_next = PH_OFF;
    end
  end

  // gate control follows the phase
  wire act_n   = (ph_next == PH_PRE) || (ph_next == PH_POST) || (ph_next == PH_CCP_OFF);
  wire fw_n    = mapped && (ph_next == PH_OFF);
  wire act_up  = act_n && !act_on;
  wire fw_up   = fw_n && !fw_on;
  wire [4:0] cur_n = (ph_next == PH_PRE)    ? ipre_cl :
                     (ph_next == PH_POST)   ? imax :
                     (ph_next == PH_PREDIS) ? (adapt ? ipdc_cl : imax) : 5'h00;
  wire [7:0] blk_n = act_up ? blk_act : fw_up ? blk_fw :
                     (blk_reg == 8'h00) ? 8'h00 : blk_reg - 8'h01;

  // one step per edge toward the target, clamped to 0..imax
  wire [4:0] ipre_n = !on_hit || !adapt    ? ipre_cl :
                      (dly_reg > tgt_on)   ? ((ipre_cl < imax) ? ipre_cl + 5'h01 : imax) :
                      (dly_reg < tgt_on)   ? ((ipre_cl != 5'h00) ? ipre_cl - 5'h01 : 5'h00) : ipre_cl;
  wire [4:0] ipdc_n = !off_hit || !adapt   ? ipdc_cl :
                      (dly_reg > tgt_off)  ? ((ipdc_cl < imax) ? ipdc_cl + 5'h01 : imax) :
                      (dly_reg < tgt_off)  ? ((ipdc_cl != 5'h00) ? ipdc_cl - 5'h01 : 5'h00) : ipdc_cl;

  // delay counter restarts at the end of each protection time
  wire [7:0] dly_n = ((ph_reg == PH_CCP_ON) || (ph_reg == PH_CCP_OFF)) ? 8'h00 :
                     dly_sat ? dly_reg : dly_reg + 8'h01;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ph_reg <= PH_OFF;
      tmr_reg <= 8'h00;
      dly_reg <= 8'h00;
      blk_reg <= 8'h00;
      seen_reg <= 1'b0;
      pwm_reg <= 1'b0;
    end else if (ce) begin
      ph_reg <= ph_next;
      tmr_reg <= tmr_next;
      dly_reg <= dly_n;
      blk_reg <= blk_n;
      seen_reg <= meas_ph && (seen_reg || on_hit);
      pwm_reg <= pwm;
    end
  end

  // outputs and adapted currents
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      act_on <= 1'b0;
      fw_on <= 1'b0;
      blanking <= 1'b0;
      cur <= 5'h00;
      meas_on <= 8'h00;
      meas_off <= 8'h00;
      ipre <= CUR_INIT;
      ipdc <= CUR_INIT;
    end else if (ce) begin
      act_on <= act_n;
      fw_on <= fw_n;
      blanking <= (blk_n != 8'h00);
      cur <= cur_n;
      meas_on <= on_hit ? dly_reg : meas_on;
      meas_off <= off_hit ? dly_reg : meas_off;
      ipre <= ipre_n;
      ipdc <= ipdc_n;
    end
  end

endmodule

// File: core/agd_top.sv
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module agd_top
  import agd_pkg::*;
(
  input  wire logic        clk,             // core clock, 200 MHz
  input  wire logic        rstn,            // async reset, active low
  input  wire logic        ce,              // clock enable
  input  wire logic        psel,            // apb select
  input  wire logic        penable,         // apb enable
  input  wire logic        pwrite,          // apb direction
  input  wire logic [7:0]  paddr,           // apb byte address
  input  wire logic [31:0] pwdata,          // apb write data
  output logic [31:0]      prdata,          // apb read data
  output logic             pready,          // apb ready
  output logic             pslverr,         // apb error, unmapped address or write to a read-only address
  input  wire logic [2:0]  pwm_input_pin,   // waveform per channel
  input  wire logic [7:0]  vsh_above_high,  // switch node above upper level
  input  wire logic [7:0]  vsh_below_low,   // switch node below lower level
  input  wire logic [7:0]  vds_overvoltage, // raw drain-source comparators
  output logic [7:0]       gate_hs_on,      // high-side gate on
  output logic [7:0]       gate_ls_on,      // low-side gate on
  output logic [7:0]       vds_fault,       // unmasked overvoltage
  output logic [14:0]      gate_current     // five bits per channel
);

  // register storage
  logic [1:0]  general_control_word_two;
  logic [15:0] halfbridge_mode;
  logic [5:0]  pwm_cfg_reg [NUM_CH];
  logic [15:0] target_delay_ch [NUM_CH];
  logic [4:0]  max_drive_current_ch [NUM_CH];
  logic [31:0] hb_time_reg [NUM_HB];
  logic [7:0]  conflict_reg;

  // per-channel wires
  logic [7:0] measured_delay_on [NUM_CH];
  logic [7:0] measured_delay_off [NUM_CH];
  logic [4:0] precharge_current_ch [NUM_CH];
  logic [4:0] predischarge_current_ch [NUM_CH];
  logic [4:0] ch_cur [NUM_CH];
  logic [2:0] ch_act, ch_fw, ch_blank, ch_mapped, ch_hs;
  logic [7:0] hb_hs_n, hb_ls_n, hb_blank, hb_conf;

  // apb access phase takes two cycles; pready comes from a flop
  wire acc     = psel & penable & ~pready;
  wire wr_fire = psel & penable & pready & pwrite;
  wire adaptive_gate_select = general_control_word_two[AGS_ADAPT_BIT];

  // read mux
  logic [31:0] rd_data;
  logic        rd_hit;
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (paddr == OFF_GEN) rd_data = 32'(general_control_word_two);
    else if (paddr == OFF_HALFBRIDGE_MODE) rd_data = 32'(halfbridge_mode);
    else if (paddr == OFF_STATUS) rd_data = {16'h0000, conflict_reg, vds_fault};
    else rd_hit = 1'b0;
    for (int z = 0; z < NUM_CH; z++) begin
      if (paddr == OFF_PWMCFG + 8'(4 * z)) begin rd_data = 32'(pwm_cfg_reg[z]); rd_hit = 1'b1; end
      if (paddr == OFF_TARGET + 8'(4 * z)) begin rd_data = 32'(target_delay_ch[z]); rd_hit = 1'b1; end
      if (paddr == OFF_IMAX + 8'(4 * z)) begin rd_data = 32'(max_drive_current_ch[z]); rd_hit = 1'b1; end
      if (paddr == OFF_MEAS + 8'(4 * z)) begin
        rd_data = {16'h0000, measured_delay_off[z], measured_delay_on[z]};
        rd_hit = 1'b1;
      end
      if (paddr == OFF_CURR + 8'(4 * z)) begin
        rd_data = {19'h0, predischarge_current_ch[z], 3'h0, precharge_current_ch[z]};
        rd_hit = 1'b1;
      end
    end
    for (int x = 0; x < NUM_HB; x++) begin
      if (paddr == OFF_HBTIME + 8'(4 * x)) begin rd_data = hb_time_reg[x]; rd_hit = 1'b1; end
    end
  end

  // status and read-only addresses refuse writes with an error
  wire ro_addr = (paddr == OFF_STATUS) || (paddr >= OFF_MEAS && paddr < OFF_MEAS + 8'h0C) ||
                 (paddr >= OFF_CURR && paddr < OFF_CURR + 8'h0C);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= acc;
      prdata <= (acc && !pwrite) ? rd_data : prdata;
      pslverr <= acc && (!rd_hit || (pwrite && ro_addr));
    end
  end

  // single-word registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      general_control_word_two <= GEN_RST;
      halfbridge_mode <= HALFBRIDGE_MODE_RST;
    end else if (ce && wr_fire) begin
      if (paddr == OFF_GEN) general_control_word_two <= pwdata[GEN_AGS_LSB +: 2];
      if (paddr == OFF_HALFBRIDGE_MODE) halfbridge_mode <= pwdata[15:0];
    end
  end

  // per-channel registers and channel engines
  genvar gz;
  generate
    for (gz = 0; gz < NUM_CH; gz++) begin : g_ch
      wire [5:0] cfg  = pwm_cfg_reg[gz];
      wire [2:0] hbs  = cfg[PWM_HB_LSB +: 3];
      wire [1:0] mode = halfbridge_mode[2 * hbs +: 2];
      wire [31:0] ht  = hb_time_reg[hbs];
      wire [1:0] tp   = cfg[PWM_TP_LSB +: 2];
      wire [7:0] tpc  = (tp == 2'h0) ? TPCHG0_CYC : (tp == 2'h1) ? TPCHG1_CYC :
                        (tp == 2'h2) ? TPCHG2_CYC : TPCHG3_CYC;
      wire fb_rise = !vsh_below_low[hbs];
      wire fb_fall = !vsh_above_high[hbs];
      assign ch_hs[gz]     = (mode == HB_MODE_HS);
      assign ch_mapped[gz] = cfg[PWM_EN_BIT] && (mode == HB_MODE_HS || mode == HB_MODE_LS) &&
                             !hb_conf[hbs];

      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          pwm_cfg_reg[gz] <= PWMCFG_RST;
          target_delay_ch[gz] <= TARGET_RST;
          max_drive_current_ch[gz] <= IMAX_RST;
        end else if (ce && wr_fire) begin
          if (paddr == OFF_PWMCFG + 8'(4 * gz)) pwm_cfg_reg[gz] <= pwdata[5:0];
          if (paddr == OFF_TARGET + 8'(4 * gz)) target_delay_ch[gz] <= pwdata[15:0];
          if (paddr == OFF_IMAX + 8'(4 * gz)) max_drive_current_ch[gz] <= pwdata[4:0];
        end
      end

      agd_chan u_chan (
        .clk      (clk),
        .rstn     (rstn),
        .ce       (ce),
        .mapped   (ch_mapped[gz]),
        .adapt    (adaptive_gate_select),
        .pwm      (pwm_input_pin[gz]),
        .fb_on    (ch_hs[gz] ? fb_rise : fb_fall),
        .fb_off   (ch_hs[gz] ? fb_fall : fb_rise),
        .ccp_act  (ht[HT_CCPA_LSB +: 8]),
        .ccp_fw   (ht[HT_CCPF_LSB +: 8]),
        .blk_act  (ht[HT_BLKA_LSB +: 8]),
        .blk_fw   (ht[HT_BLKF_LSB +: 8]),
        .tpchg    (tpc),
        .tgt_on   (target_delay_ch[gz][TGT_ON_LSB +: 8]),
        .tgt_off  (target_delay_ch[gz][TGT_OFF_LSB +: 8]),
        .imax     (max_drive_current_ch[gz]),
        .act_on   (ch_act[gz]),
        .fw_on    (ch_fw[gz]),
        .blanking (ch_blank[gz]),
        .cur      (ch_cur[gz]),
        .meas_on  (measured_delay_on[gz]),
        .meas_off (measured_delay_off[gz]),
        .ipre     (precharge_current_ch[gz]),
        .ipdc     (predischarge_current_ch[gz])
      );
    end
  endgenerate

  // per half-bridge timing registers and gate routing
  genvar gx;
  generate
    for (gx = 0; gx < NUM_HB; gx++) begin : g_hb
      wire [2:0] hit;
      for (genvar k = 0; k < NUM_CH; k++) begin : g_hit
        assign hit[k] = pwm_cfg_reg[k][PWM_EN_BIT] && (pwm_cfg_reg[k][PWM_HB_LSB +: 3] == 3'(gx));
      end
      wire [1:0] mode = halfbridge_mode[2 * gx +: 2];
      wire pwm_mode   = (mode == HB_MODE_HS) || (mode == HB_MODE_LS);
      // two enabled channels on one bridge: both transistors forced off
      assign hb_conf[gx]  = pwm_mode && (hit[0] + hit[1] + hit[2] > 2'd1);
      wire [2:0] own      = hit & ch_mapped;
      wire act            = |(own & ch_act);
      wire fw             = |(own & ch_fw);
      assign hb_hs_n[gx]  = (mode == HB_MODE_HS) ? act : (mode == HB_MODE_LS) && fw;
      assign hb_ls_n[gx]  = (mode == HB_MODE_LS) ? act : (mode == HB_MODE_HS) && fw;
      assign hb_blank[gx] = |(own & ch_blank);

      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          hb_time_reg[gx] <= HBTIME_RST;
        end else if (ce && wr_fire && paddr == OFF_HBTIME + 8'(4 * gx)) begin
          hb_time_reg[gx] <= pwdata;
        end
      end
    end
  endgenerate

  // gate and fault outputs, registered
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gate_hs_on <= 8'h00;
      gate_ls_on <= 8'h00;
      vds_fault <= 8'h00;
      conflict_reg <= 8'h00;
      gate_current <= 15'h0000;
    end else if (ce) begin
      gate_hs_on <= hb_hs_n;
      gate_ls_on <= hb_ls_n;
      vds_fault <= vds_overvoltage & ~hb_blank;
      conflict_reg <= hb_conf;
      gate_current <= {ch_cur[2], ch_cur[1], ch_cur[0]};
    end
  end

endmodule

// File: verif/agd_sva.sv
`timescale 1ns/1ps
module agd_sva
  import agd_pkg::*;
(
  input wire logic        clk,             // core clock
  input wire logic        rstn,            // reset, low
  input wire logic        ce,              // clock enable
  input wire logic        psel,            // apb select
  input wire logic        penable,         // apb enable
  input wire logic        pwrite,          // apb direction
  input wire logic [7:0]  paddr,           // apb address
  input wire logic [31:0] pwdata,          // apb write data
  input wire logic [31:0] prdata,          // apb read data
  input wire logic        pready,          // apb ready
  input wire logic        pslverr,         // apb error
  input wire logic [7:0]  gate_hs_on,      // high-side gates
  input wire logic [7:0]  gate_ls_on,      // low-side gates
  input wire logic [7:0]  vds_overvoltage, // raw comparators
  input wire logic [7:0]  vds_fault,       // masked faults
  input wire logic [14:0] gate_current     // current codes
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  logic [4:0] imax0_reg; // channel 0 limit as last written
  logic [2:0] age_reg;   // cycles since that write, saturating
  wire        done_w = psel & penable & pready & ce;
  wire        ro_w   = (paddr == OFF_MEAS) || (paddr == OFF_STATUS) || (paddr == 8'h2C);

  // shadow the limit so the clamp is judged without reading registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      imax0_reg <= IMAX_RST;
      age_reg   <= 3'h0;
    end else if (done_w && pwrite && paddr == OFF_IMAX) begin
      imax0_reg <= pwdata[4:0];
      age_reg   <= 3'h0;
    end else if (age_reg != 3'h7) begin
      age_reg <= age_reg + 3'h1;
    end
  end

  a_apb_one_wait: assert property ((psel && !penable && ce) ##1 (psel && penable && ce) |-> !pready ##1 pready)
    else $error("ready not in second access cycle");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error raised without ready");
  a_ro_write_err: assert property (done_w && pwrite && ro_w |-> pslverr)
    else $error("write to read-only or unmapped place not refused");
  a_rdata_hold: assert property ($changed(prdata) |-> $past(psel && penable && !pwrite))
    else $error("read data moved without a read");
  a_no_overlap: assert property ((gate_hs_on & gate_ls_on) == 8'h00)
    else $error("both gates of one bridge on");
  a_dead_gap: assert property (((gate_hs_on & $past(gate_ls_on)) | (gate_ls_on & $past(gate_hs_on))) == 8'h00)
    else $error("gate handover without protection gap");
  a_current_clamp: assert property ($changed(gate_current[4:0]) && age_reg == 3'h7 |-> gate_current[4:0] <= imax0_reg)
    else $error("channel current above its limit");
  a_fault_from_raw: assert property ((vds_fault & ~($past(vds_overvoltage) | $past(vds_overvoltage, 2))) == 8'h00)
    else $error("fault without raw overvoltage");

  c_refused: cover property (done_w && pslverr);
  c_active_on: cover property ($rose(gate_hs_on[2]));
  c_fault_seen: cover property (vds_fault != 8'h00);
endmodule

bind agd_top agd_sva u_agd_sva (.clk, .rstn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .gate_hs_on, .gate_ls_on, .vds_overvoltage, .vds_fault, .gate_current);

// File: verif/agd_hb_model.sv
`timescale 1ns/1ps
module agd_hb_model
  import agd_pkg::*;
(
  input  wire logic       clk,        // core clock
  input  wire logic       rstn,       // reset, low
  input  wire logic [7:0] hs_on,      // high-side gates
  input  wire logic [7:0] ls_on,      // low-side gates
  input  wire logic [7:0] load_src,   // load pulls node low when off
  input  wire logic [7:0] dly,        // node slew in cycles
  output logic      [7:0] above_high, // node above upper level
  output logic      [7:0] below_low   // node below lower level
);
  logic [7:0] node_reg;
  logic [7:0] cnt_reg [NUM_HB];
  logic [7:0] goal;

  // with both gates off the load current decides where the node goes
  always_comb begin
    for (int x = 0; x < NUM_HB; x++) begin
      goal[x] = hs_on[x] ? 1'b1 : (ls_on[x] ? 1'b0 : ~load_src[x]);
    end
  end

  // node flips dly+1 cycles after its goal changes; no level between the rails is modelled
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      node_reg <= 8'h00;
      for (int x = 0; x < NUM_HB; x++) cnt_reg[x] <= 8'h00;
    end else begin
      for (int x = 0; x < NUM_HB; x++) begin
        if (node_reg[x] == goal[x]) begin
          cnt_reg[x] <= 8'h00;
        end else if (cnt_reg[x] >= dly) begin
          node_reg[x] <= goal[x];
          cnt_reg[x]  <= 8'h00;
        end else begin
          cnt_reg[x] <= cnt_reg[x] + 8'h01;
        end
      end
    end
  end

  assign above_high = node_reg;
  assign below_low  = ~node_reg;
endmodule

// File: verif/agd_top_tb.sv
`timescale 1ns/1ps
module agd_top_tb
  import agd_pkg::*;
;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        ce = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err, f_early, f_late;
  logic [7:0]  paddr = 8'h00, vds_ov = 8'h00, dly = 8'h06, ahi, blo, hs, ls, vflt;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [2:0]  pwm = 3'h0;
  logic [14:0] gcur;
  int          mismatches = 0, checked = 0, t_on, t_pre, t_off;

  always #2.5 clk = ~clk;

  agd_top u_agd_top (.clk, .rstn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .pwm_input_pin(pwm), .vsh_above_high(ahi), .vsh_below_low(blo), .vds_overvoltage(vds_ov),
    .gate_hs_on(hs), .gate_ls_on(ls), .vds_fault(vflt), .gate_current(gcur));
  // only bridge 2 carries a sourcing load, matching its high-side use
  agd_hb_model u_agd_hb_model (.clk, .rstn, .hs_on(hs), .ls_on(ls), .load_src(8'h04), .dly,
    .above_high(ahi), .below_low(blo));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one transfer; ready, read data and error are all taken at the completing rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) mismatches++;
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, err}, {31'h0, exp_err});
  endtask

  // one high phase on channel 0 (bridge 2, high side); loops are bounded
  task automatic pulse(input int hi, input logic [4:0] imax);
    int n = 0;
    t_on = 0;
    t_pre = 2;
    t_off = 0;
    @(posedge clk);
    pwm[0] <= 1'b1;
    while (hs[2] !== 1'b1 && t_on < 400) begin
      @(negedge clk);
      t_on++;
    end
    repeat (2) @(negedge clk);
    f_early = vflt[2];
    while (gcur[4:0] !== imax && t_pre < 400) begin
      @(negedge clk);
      t_pre++;
    end
    repeat (hi) @(negedge clk);
    f_late = vflt[2];
    @(posedge clk);
    pwm[0] <= 1'b0;
    while (hs[2] !== 1'b0 && t_off < 400) begin
      @(negedge clk);
      t_off++;
    end
    while (ls[2] !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    repeat (20) @(negedge clk);
  endtask

  task automatic t_regs();
    rdchk(OFF_TARGET, {16'h0, TARGET_RST}, 1'b0);
    rdchk(OFF_IMAX, {27'h0, IMAX_RST}, 1'b0);
    rdchk(OFF_HBTIME, HBTIME_RST, 1'b0);
    rdchk(OFF_CURR, {19'h0, CUR_INIT, 3'h0, CUR_INIT}, 1'b0);
    wr(OFF_MEAS, 32'hFFFFFFFF);
    chk({31'h0, err}, 32'h1);
    rdchk(OFF_MEAS, 32'h0, 1'b0);
    rdchk(8'h2C, 32'h0, 1'b1);
  endtask

  // bridge 0 and 2 high side, bridge 7 low side; idle shows freewheel gates
  task automatic t_map();
    wr(OFF_HALFBRIDGE_MODE, 32'h00004022);
    wr(OFF_PWMCFG, 32'h00000005);
    wr(OFF_PWMCFG + 8'h04, 32'h0000000F);
    wr(OFF_PWMCFG + 8'h08, 32'h00000001);
    repeat (4) @(negedge clk);
    chk({16'h0, hs, ls}, 32'h00008005);
    // frozen clock enable: a rising pin must leave every gate alone
    @(posedge clk);
    ce     <= 1'b0;
    pwm[1] <= 1'b1;
    repeat (40) @(negedge clk);
    chk({16'h0, hs, ls}, 32'h00008005);
    @(posedge clk);
    ce     <= 1'b1;
    pwm[1] <= 1'b0;
  endtask

  // prompt node, distinct protection times, overvoltage held during the pulse
  task automatic t_timing();
    wr(OFF_HBTIME + 8'h08, 32'h10102008);
    dly    <= 8'h01;
    vds_ov <= 8'h04;
    pulse(60, IMAX_RST);
    chk(32'(t_on inside {[31:38]}), 32'h1);
    chk(32'(t_off inside {[8:13]}), 32'h1);
    chk(32'(t_pre), 32'h2);
    chk({30'h0, f_early, f_late}, 32'h1);
    rdchk(OFF_STATUS, 32'h00000004, 1'b0);
  endtask

  // slow node against short and long targets; steps stop at the limits
  task automatic t_adapt();
    wr(OFF_IMAX, 32'h00000006);
    dly    <= 8'h06;
    vds_ov <= 8'h00;
    wr(OFF_TARGET, 32'h0000FF02);
    wr(OFF_GEN, 32'h00000002);
    rdchk(OFF_TARGET + 8'h04, {16'h0, TARGET_RST}, 1'b0);
    pulse(60, 5'h06);
    chk(32'(t_pre inside {[19:24]}), 32'h1);
    repeat (3) pulse(60, 5'h06);
    rdchk(OFF_CURR, 32'h00000006, 1'b0);
    apb(1'b0, OFF_MEAS, 32'h0);
    chk(32'(rd[7:0] inside {[8'h04:8'h09]}), 32'h1);
    wr(OFF_GEN, 32'h00000001);
    wr(OFF_TARGET, 32'h000000FF);
    pulse(60, 5'h06);
    chk(32'(t_pre), 32'h2);
    rdchk(OFF_CURR, 32'h00000006, 1'b0);
    wr(OFF_GEN, 32'h00000003);
    wr(OFF_PWMCFG, 32'h00000015);
    repeat (2) pulse(60, 5'h06);
    chk(32'(t_pre inside {[39:44]}), 32'h1);
    rdchk(OFF_CURR, 32'h00000204, 1'b0);
  endtask

  task automatic final_report();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_map();
    t_timing();
    t_adapt();
    final_report();
  end

  // whole run is about 1500 cycles; this cuts a hang well past that
  initial begin
    #60000;
    mismatches++;
    final_report();
  end
endmodule
